//--- mcr_pkg.sv
// shared constants, reset values and carrier types for the modem configuration bank
package mcr_pkg;
    // register addresses on the serial port
    localparam logic [5:0] ADDR_CARRIER_WORD_A_MID = 6'h0e;
    localparam logic [5:0] ADDR_CARRIER_WORD_A_LOW = 6'h0f;
    localparam logic [5:0] ADDR_BW_RATE = 6'h10;
    localparam logic [5:0] ADDR_RATE_MANT = 6'h11;
    localparam logic [5:0] ADDR_MOD_SYNC = 6'h12;
    // header byte layout
    localparam int HDR_READ_BIT = 7;
    localparam int HDR_BURST_BIT = 6;
    localparam int HDR_ADDR_W = 6;
    // field positions
    localparam int BW_EXP_LSB = 6;
    localparam int BW_MANT_LSB = 4;
    localparam int RATE_EXP_LSB = 0;
    localparam int DC_BYPASS_BIT = 7;
    localparam int MOD_LSB = 4;
    localparam int MANCH_BIT = 3;
    localparam int SYNC_LSB = 0;
    // field and register reset values
    localparam logic [7:0] RST_CARRIER_WORD_A_MID = 8'hc4;
    localparam logic [7:0] RST_CARRIER_WORD_A_LOW = 8'hec;
    localparam logic [1:0] RST_BW_EXP = 2'h2;
    localparam logic [1:0] RST_BW_MANT = 2'h0;
    localparam logic [3:0] RST_RATE_EXP = 4'hc;
    localparam logic [7:0] RST_RATE_MANT = 8'h22;
    localparam logic RST_DC_BYPASS = 1'b0;
    localparam logic [2:0] RST_MOD = 3'h0;
    localparam logic RST_MANCH = 1'b0;
    localparam logic [2:0] RST_SYNC = 3'h2;
    localparam logic [7:0] RST_BW_RATE = {RST_BW_EXP, RST_BW_MANT, RST_RATE_EXP};
    localparam logic [7:0] RST_MOD_SYNC = {RST_DC_BYPASS, RST_MOD, RST_MANCH, RST_SYNC};
    // modulation codes
    localparam logic [2:0] MOD_2FSK = 3'h0;
    localparam logic [2:0] MOD_GFSK = 3'h1;
    localparam logic [2:0] MOD_OOK = 3'h3;
    localparam logic [2:0] MOD_4FSK = 3'h4;
    // sync qualifier low two bits and tolerated bit errors
    localparam logic [1:0] SYNC_NONE = 2'h0;
    localparam logic [1:0] SYNC_16_LOOSE = 2'h1;
    localparam logic [1:0] SYNC_32 = 2'h3;
    localparam logic [1:0] ERR_16_LOOSE = 2'h1;
    localparam logic [1:0] ERR_32 = 2'h2;
    localparam logic [8:0] RATE_HIDDEN_ONE = 9'h100;
    localparam logic [8:0] BW_MANT_BASE = 9'h004;
    localparam int BW_DIV_SHIFT = 3;

    typedef enum logic {MCR_SPI_HEADER, MCR_SPI_DATA} mcr_spi_state_t;

    // decoded settings handed to the modem datapath
    typedef struct packed {
        logic [23:0] carrier_word_a;
        logic [1:0] bandwidth_exponent;
        logic [1:0] bandwidth_mantissa;
        logic [8:0] decimation_ratio;
        logic [3:0] rate_exponent;
        logic [8:0] rate_mantissa;
        logic dc_block_bypass;
        logic [2:0] modulation_select;
        logic modulation_reserved;
        logic manchester_en;
        logic manchester_conflict;
        logic sync_check_en;
        logic sync_word_32;
        logic [1:0] sync_max_errors;
        logic carrier_sense_req;
    } mcr_modem_cfg_t;
endpackage : mcr_pkg

//--- mcr_sync2.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module mcr_sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    // first stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= RESET_VAL;
            q <= RESET_VAL;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule : mcr_sync2
`default_nettype wire

//--- mcr_modem_cfg.sv
// modem configuration register bank behind a serial peripheral port
`timescale 1ns/1ps
`default_nettype none
module mcr_modem_cfg (
    input wire logic clk,
    input wire logic rst,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    input wire logic [5:0] carrier_carrier_word_a_high,
    output logic spi_miso,
    output logic spi_miso_oe,
    output mcr_pkg::mcr_modem_cfg_t modem_cfg
);
    logic sclk_s, cs_n_s, mosi_s;
    logic sclk_d_reg;
    logic rise, fall;
    mcr_pkg::mcr_spi_state_t state_reg, state_next;
    logic [2:0] bit_cnt_reg, bit_cnt_next;
    logic [6:0] rx_sh_reg, rx_sh_next;
    logic [7:0] tx_sh_reg, tx_sh_next;
    logic [5:0] addr_reg, addr_next;
    logic rd_reg, rd_next, burst_reg, burst_next;
    logic load_reg, load_next;
    logic miso_next, miso_oe_next;
    logic [7:0] in_byte, rdata;
    logic wr_en;
    logic [5:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] carrier_word_a_mid_reg, carrier_word_a_mid_next, carrier_word_a_low_reg, carrier_word_a_low_next;
    logic [7:0] bw_rate_reg, bw_rate_next, rate_mant_reg, rate_mant_next;
    logic [7:0] mod_sync_reg, mod_sync_next;
    mcr_pkg::mcr_modem_cfg_t cfg_next;

    // pins pass two flops before use
    mcr_sync2 #(.W(3), .RESET_VAL(3'h2)) u_pin_sync (
        .clk(clk),
        .rst(rst),
        .d({spi_sclk, spi_cs_n, spi_mosi}),
        .q({sclk_s, cs_n_s, mosi_s})
    );

    assign rise = sclk_s & ~sclk_d_reg;
    assign fall = ~sclk_s & sclk_d_reg;
    assign in_byte = {rx_sh_reg, mosi_s};

    // read mux, unmapped addresses read zero
    always_comb begin
        case (addr_reg)
            mcr_pkg::ADDR_CARRIER_WORD_A_MID: rdata = carrier_word_a_mid_reg;
            mcr_pkg::ADDR_CARRIER_WORD_A_LOW: rdata = carrier_word_a_low_reg;
            mcr_pkg::ADDR_BW_RATE: rdata = bw_rate_reg;
            mcr_pkg::ADDR_RATE_MANT: rdata = rate_mant_reg;
            mcr_pkg::ADDR_MOD_SYNC: rdata = mod_sync_reg;
            default: rdata = 8'h00;
        endcase
    end

    // serial engine: sample on rising sclk, shift out on falling sclk
    always_comb begin
        state_next = state_reg;
        bit_cnt_next = bit_cnt_reg;
        rx_sh_next = rx_sh_reg;
        tx_sh_next = tx_sh_reg;
        addr_next = addr_reg;
        rd_next = rd_reg;
        burst_next = burst_reg;
        load_next = load_reg;
        wr_en = 1'b0;
        wr_addr = addr_reg;
        wr_data = in_byte;
        miso_oe_next = ~cs_n_s;
        if (cs_n_s) begin
            state_next = mcr_pkg::MCR_SPI_HEADER;
            bit_cnt_next = 3'h0;
            tx_sh_next = 8'h00;
            load_next = 1'b0;
        end else if (rise) begin
            rx_sh_next = in_byte[6:0];
            bit_cnt_next = bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7) begin
                case (state_reg)
                    mcr_pkg::MCR_SPI_HEADER: begin
                        addr_next = in_byte[mcr_pkg::HDR_ADDR_W-1:0];
                        rd_next = in_byte[mcr_pkg::HDR_READ_BIT];
                        burst_next = in_byte[mcr_pkg::HDR_BURST_BIT];
                        load_next = in_byte[mcr_pkg::HDR_READ_BIT];
                        state_next = mcr_pkg::MCR_SPI_DATA;
                    end
                    mcr_pkg::MCR_SPI_DATA: begin
                        wr_en = ~rd_reg;
                        addr_next = burst_reg ? addr_reg + 6'h01 : addr_reg;
                        load_next = rd_reg;
                    end
                    default: state_next = mcr_pkg::MCR_SPI_HEADER;
                endcase
            end
        end else if (fall) begin
            if (load_reg) begin
                tx_sh_next = rdata;
                load_next = 1'b0;
            end else begin
                tx_sh_next = {tx_sh_reg[6:0], 1'b0};
            end
        end
        miso_next = tx_sh_next[7];
    end

    // serial engine registers
    always_ff @(posedge clk) begin
        if (rst) begin
            sclk_d_reg <= 1'b0;
            state_reg <= mcr_pkg::MCR_SPI_HEADER;
            bit_cnt_reg <= 3'h0;
            rx_sh_reg <= 7'h00;
            tx_sh_reg <= 8'h00;
            addr_reg <= 6'h00;
            rd_reg <= 1'b0;
            burst_reg <= 1'b0;
            load_reg <= 1'b0;
            spi_miso <= 1'b0;
            spi_miso_oe <= 1'b0;
        end else begin
            sclk_d_reg <= sclk_s;
            state_reg <= state_next;
            bit_cnt_reg <= bit_cnt_next;
            rx_sh_reg <= rx_sh_next;
            tx_sh_reg <= tx_sh_next;
            addr_reg <= addr_next;
            rd_reg <= rd_next;
            burst_reg <= burst_next;
            load_reg <= load_next;
            spi_miso <= miso_next;
            spi_miso_oe <= miso_oe_next;
        end
    end

    // register writes; reserved modulation codes are stored as written
    always_comb begin
        carrier_word_a_mid_next = carrier_word_a_mid_reg;
        carrier_word_a_low_next = carrier_word_a_low_reg;
        bw_rate_next = bw_rate_reg;
        rate_mant_next = rate_mant_reg;
        mod_sync_next = mod_sync_reg;
        if (wr_en) begin
            case (wr_addr)
                mcr_pkg::ADDR_CARRIER_WORD_A_MID: carrier_word_a_mid_next = wr_data;
                mcr_pkg::ADDR_CARRIER_WORD_A_LOW: carrier_word_a_low_next = wr_data;
                mcr_pkg::ADDR_BW_RATE: bw_rate_next = wr_data;
                mcr_pkg::ADDR_RATE_MANT: rate_mant_next = wr_data;
                mcr_pkg::ADDR_MOD_SYNC: mod_sync_next = wr_data;
                default: mod_sync_next = mod_sync_reg;
            endcase
        end
    end

    // register storage with power-on defaults
    always_ff @(posedge clk) begin
        if (rst) begin
            carrier_word_a_mid_reg <= mcr_pkg::RST_CARRIER_WORD_A_MID;
            carrier_word_a_low_reg <= mcr_pkg::RST_CARRIER_WORD_A_LOW;
            bw_rate_reg <= mcr_pkg::RST_BW_RATE;
            rate_mant_reg <= mcr_pkg::RST_RATE_MANT;
            mod_sync_reg <= mcr_pkg::RST_MOD_SYNC;
        end else begin
            carrier_word_a_mid_reg <= carrier_word_a_mid_next;
            carrier_word_a_low_reg <= carrier_word_a_low_next;
            bw_rate_reg <= bw_rate_next;
            rate_mant_reg <= rate_mant_next;
            mod_sync_reg <= mod_sync_next;
        end
    end

    // decode fields into datapath settings
    always_comb begin
        logic [2:0] mod;
        logic [1:0] sq;
        mod = mod_sync_reg[mcr_pkg::MOD_LSB +: 3];
        sq = mod_sync_reg[mcr_pkg::SYNC_LSB +: 2];
        cfg_next = '0;
        cfg_next.carrier_word_a = {2'b00, carrier_carrier_word_a_high, carrier_word_a_mid_reg, carrier_word_a_low_reg};
        cfg_next.bandwidth_exponent = bw_rate_reg[mcr_pkg::BW_EXP_LSB +: 2];
        cfg_next.bandwidth_mantissa = bw_rate_reg[mcr_pkg::BW_MANT_LSB +: 2];
        cfg_next.decimation_ratio = (({7'h00, cfg_next.bandwidth_mantissa}
            + mcr_pkg::BW_MANT_BASE) << mcr_pkg::BW_DIV_SHIFT)
            << cfg_next.bandwidth_exponent;
        cfg_next.rate_exponent = bw_rate_reg[mcr_pkg::RATE_EXP_LSB +: 4];
        cfg_next.rate_mantissa = mcr_pkg::RATE_HIDDEN_ONE | {1'b0, rate_mant_reg};
        cfg_next.dc_block_bypass = mod_sync_reg[mcr_pkg::DC_BYPASS_BIT];
        cfg_next.modulation_select = mod;
        cfg_next.modulation_reserved = !(mod inside {mcr_pkg::MOD_2FSK, mcr_pkg::MOD_GFSK,
            mcr_pkg::MOD_OOK, mcr_pkg::MOD_4FSK});
        cfg_next.manchester_en = mod_sync_reg[mcr_pkg::MANCH_BIT];
        cfg_next.manchester_conflict = mod_sync_reg[mcr_pkg::MANCH_BIT]
            && (mod == mcr_pkg::MOD_4FSK);
        cfg_next.sync_check_en = (sq != mcr_pkg::SYNC_NONE);
        cfg_next.sync_word_32 = (sq == mcr_pkg::SYNC_32);
        if (sq == mcr_pkg::SYNC_16_LOOSE) begin
            cfg_next.sync_max_errors = mcr_pkg::ERR_16_LOOSE;
        end else if (sq == mcr_pkg::SYNC_32) begin
            cfg_next.sync_max_errors = mcr_pkg::ERR_32;
        end
        cfg_next.carrier_sense_req = mod_sync_reg[mcr_pkg::SYNC_LSB + 2];
    end

    // decoded settings leave from flops
    always_ff @(posedge clk) begin
        if (rst) begin
            modem_cfg <= '0;
        end else begin
            modem_cfg <= cfg_next;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_carrier_word_a_mid_rst;
        $fell(rst) |-> carrier_word_a_mid_reg == 8'hc4 ##1 modem_cfg.carrier_word_a[15:8] == 8'hc4;
    endproperty
    a_carrier_word_a_mid_rst: assert property (p_carrier_word_a_mid_rst) else $error("mid byte reset");

    property p_carrier_word_a_low_rst;
        $fell(rst) |-> ##1 modem_cfg.carrier_word_a[7:0] == 8'hec;
    endproperty
    a_carrier_word_a_low_rst: assert property (p_carrier_word_a_low_rst) else $error("low byte reset");

    property p_decim;
        !$past(rst) |-> modem_cfg.decimation_ratio == 9'((4 + 32'($past(bw_rate_reg[5:4])))
            * 8 * (1 << $past(bw_rate_reg[7:6])));
    endproperty
    a_decim: assert property (p_decim) else $error("decimation ratio wrong");

    property p_rate_exp_rst;
        $fell(rst) |-> ##1 modem_cfg.rate_exponent == 4'hc && modem_cfg.decimation_ratio == 9'h080;
    endproperty
    a_rate_exp_rst: assert property (p_rate_exp_rst) else $error("rate exponent reset");

    property p_rate_mant;
        !$past(rst) |-> modem_cfg.rate_mantissa == {1'b1, $past(rate_mant_reg)};
    endproperty
    a_rate_mant: assert property (p_rate_mant) else $error("hidden mantissa bit");

    property p_dc_bypass;
        !$past(rst) |-> modem_cfg.dc_block_bypass == $past(mod_sync_reg[7]);
    endproperty
    a_dc_bypass: assert property (p_dc_bypass) else $error("dc bypass bit");

    property p_mod_res;
        !$past(rst) |-> modem_cfg.modulation_reserved == ($past(mod_sync_reg[6:4]) inside
            {3'h2, 3'h5, 3'h6, 3'h7});
    endproperty
    a_mod_res: assert property (p_mod_res) else $error("reserved modulation flag");

    property p_sync_off;
        !$past(rst) && $past(mod_sync_reg[1:0]) == 2'h0 |-> !modem_cfg.sync_check_en;
    endproperty
    a_sync_off: assert property (p_sync_off) else $error("sync detection not off");

    property p_sync16;
        !$past(rst) && $past(mod_sync_reg[1]) != $past(mod_sync_reg[0]) |->
            !modem_cfg.sync_word_32 && modem_cfg.sync_max_errors == {1'b0, $past(mod_sync_reg[0])};
    endproperty
    a_sync16: assert property (p_sync16) else $error("16-bit sync tolerance");

    property p_sync32;
        !$past(rst) && $past(mod_sync_reg[1:0]) == 2'h3 |->
            modem_cfg.sync_word_32 && modem_cfg.sync_max_errors == 2'h2;
    endproperty
    a_sync32: assert property (p_sync32) else $error("32-bit sync tolerance");

    property p_cs_req;
        !$past(rst) |-> modem_cfg.carrier_sense_req == $past(mod_sync_reg[2]);
    endproperty
    a_cs_req: assert property (p_cs_req) else $error("carrier sense qualifier");

    property p_sync_rst;
        $fell(rst) |-> ##1 modem_cfg.sync_check_en && !modem_cfg.sync_word_32
            && modem_cfg.sync_max_errors == 2'h0 && !modem_cfg.carrier_sense_req;
    endproperty
    a_sync_rst: assert property (p_sync_rst) else $error("sync qualifier reset");

    property p_top_zero;
        !$past(rst) |-> modem_cfg.carrier_word_a == {2'b00, $past(carrier_carrier_word_a_high),
            $past(carrier_word_a_mid_reg), $past(carrier_word_a_low_reg)};
    endproperty
    a_top_zero: assert property (p_top_zero) else $error("carrier top bits set");

    property p_manch;
        !$past(rst) |-> modem_cfg.manchester_conflict == ($past(mod_sync_reg[3])
            && $past(mod_sync_reg[6:4]) == 3'h4);
    endproperty
    a_manch: assert property (p_manch) else $error("manchester conflict flag");

    property p_manch_en;
        !$past(rst) |-> modem_cfg.manchester_en == $past(mod_sync_reg[3]);
    endproperty
    a_manch_en: assert property (p_manch_en) else $error("manchester enable bit");

    c_write: cover property (wr_en && wr_addr == mcr_pkg::ADDR_MOD_SYNC);
    c_read_load: cover property (fall && load_reg && !cs_n_s);
    c_burst: cover property (wr_en && burst_reg ##[1:300] wr_en);
    c_sync32: cover property (modem_cfg.sync_word_32 && modem_cfg.carrier_sense_req);
endmodule : mcr_modem_cfg
`default_nettype wire

//--- mcr_spi_host.sv
// host model: serial master that frames header and data bytes in mode 0
`timescale 1ns/1ps
`default_nettype none
module mcr_spi_host #(
    parameter int HALF = 6
) (
    input wire logic clk,
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    input wire logic miso
);
    logic [7:0] rd_q[$];

    // idle levels: clock low, device deselected
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b1;
    end

    // wait n clocks, then step just past the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    // one frame: header then data bytes; bytes seen on miso during the data bytes land in rd_q
    task automatic frame(input logic [7:0] hdr, input logic [7:0] data[$]);
        logic [7:0] sh;
        logic [7:0] rx;
        rd_q.delete();
        tick(1);
        cs_n = 1'b0;
        for (int b = 0; b <= data.size(); b++) begin
            sh = (b == 0) ? hdr : data[b-1];
            for (int i = 7; i >= 0; i--) begin
                mosi = sh[i]; // msb first, changed while the clock is low
                tick(HALF);
                rx[i] = miso; // sampled as the clock rises
                sclk = 1'b1;
                tick(HALF);
                sclk = 1'b0;
            end
            if (b > 0) begin
                rd_q.push_back(rx);
            end
        end
        tick(HALF);
        cs_n = 1'b1;
        mosi = ~mosi; // a released line keeps no stale value
        tick(4);
    endtask : frame
endmodule : mcr_spi_host
`default_nettype wire

//--- test_modem_config_registers.sv
// self-checking bench for the modem configuration bank
`timescale 1ns/1ps
`default_nettype none
module test_modem_config_registers;
    logic clk;
    logic rst;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic [5:0] carrier_word_a_high;
    mcr_pkg::mcr_modem_cfg_t cfg;
    int mismatches;
    int tests_run;
    int cycles;
    logic [7:0] v;
    logic [8:0] dec;
    logic [11:0] e;
    logic oe_seen = 1'b0;

    mcr_modem_cfg dut (.clk(clk), .rst(rst), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
        .carrier_carrier_word_a_high(carrier_word_a_high), .spi_miso(miso), .spi_miso_oe(miso_oe), .modem_cfg(cfg));
    mcr_spi_host host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

    // 25 MHz clock
    initial clk = 1'b0;
    always #20 clk = ~clk;

    // verdict and end of run
    task automatic end_sim();
        if (mismatches == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    // compare a decoded field of the settings bundle
    task automatic chk_cfg(input logic [23:0] got, input logic [23:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk_cfg

    // compare a byte read back over the serial port
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: read %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk_byte

    // single-byte register access frames
    task automatic reg_wr(input logic [5:0] a, input logic [7:0] d);
        host.frame({2'b00, a}, '{d});
    endtask : reg_wr

    task automatic reg_rd(input logic [5:0] a, input logic [7:0] exp);
        host.frame({2'b10, a}, '{8'h00});
        chk_byte(host.rd_q[0], exp, "register");
    endtask : reg_rd

    // cut a hung run short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            $display("mismatch at %0t: run timed out", $time);
            end_sim();
        end
    end

    // remember that the device drove miso during some frame
    always @(posedge clk) begin
        if (miso_oe === 1'b1) begin
            oe_seen <= 1'b1;
        end
    end

    // main sequence
    initial begin
        rst = 1'b1;
        carrier_word_a_high = 6'h1e;
        mismatches = 0;
        tests_run = 0;
        cycles = 0;
        repeat (16) @(posedge clk);
        #1;
        rst = 1'b0;
        host.tick(3);
        // reset values through the port and in the decoded bundle
        reg_rd(mcr_pkg::ADDR_CARRIER_WORD_A_MID, 8'hc4);
        reg_rd(mcr_pkg::ADDR_CARRIER_WORD_A_LOW, 8'hec);
        reg_rd(mcr_pkg::ADDR_BW_RATE, 8'h8c);
        reg_rd(mcr_pkg::ADDR_RATE_MANT, 8'h22);
        reg_rd(mcr_pkg::ADDR_MOD_SYNC, 8'h02);
        chk_cfg(cfg.carrier_word_a, 24'h1ec4ec, "carrier reset");
        chk_cfg(24'(cfg.decimation_ratio), 24'h80, "decimation reset");
        chk_cfg(24'(cfg.rate_mantissa), 24'h122, "mantissa reset");
        chk_cfg(24'({cfg.sync_check_en, cfg.sync_max_errors}), 24'h4, "sync reset");
        // burst write and burst read of both carrier bytes
        host.frame({2'b01, mcr_pkg::ADDR_CARRIER_WORD_A_MID}, '{8'h55, 8'haa});
        host.frame({2'b11, mcr_pkg::ADDR_CARRIER_WORD_A_MID}, '{8'h00, 8'h00});
        chk_byte(host.rd_q[0], 8'h55, "carrier mid");
        chk_byte(host.rd_q[1], 8'haa, "carrier low");
        carrier_word_a_high = 6'h3f;
        host.tick(2);
        chk_cfg(cfg.carrier_word_a, 24'h3f55aa, "carrier word");
        // every bandwidth exponent and mantissa, rate exponent varied alongside
        for (int k = 0; k < 16; k++) begin
            v = {k[3:0], 4'hf - k[3:0]};
            dec = 9'((32 + 8 * (k % 4)) << (k / 4));
            reg_wr(mcr_pkg::ADDR_BW_RATE, v);
            chk_cfg(24'(cfg.decimation_ratio), 24'(dec), "decimation");
            chk_cfg(24'({cfg.bandwidth_exponent, cfg.bandwidth_mantissa}), 24'(k[3:0]),
                "bandwidth fields");
            chk_cfg(24'(cfg.rate_exponent), 24'(v[3:0]), "rate exponent");
            reg_rd(mcr_pkg::ADDR_BW_RATE, v);
        end
        // mantissa extremes gain the hidden ninth bit
        for (int k = 0; k < 2; k++) begin
            v = (k == 0) ? 8'hff : 8'h00;
            reg_wr(mcr_pkg::ADDR_RATE_MANT, v);
            chk_cfg(24'(cfg.rate_mantissa), 24'({1'b1, v}), "rate mantissa");
        end
        // every modulation code and sync qualifier, reserved and conflicting ones included
        for (int i = 0; i < 8; i++) begin
            v = {i[1], i[2:0], i[2], i[2:0]};
            reg_wr(mcr_pkg::ADDR_MOD_SYNC, v);
            reg_rd(mcr_pkg::ADDR_MOD_SYNC, v);
            e = {i[1], i[2:0], (i == 2 || i > 4) ? 1'b1 : 1'b0, i[2], (i == 4) ? 1'b1 : 1'b0, 5'h0};
            chk_cfg(24'({cfg.dc_block_bypass, cfg.modulation_select, cfg.modulation_reserved,
                cfg.manchester_en, cfg.manchester_conflict, 5'h0}), 24'(e), "modulation");
            chk_cfg(24'(cfg.sync_check_en), 24'(i[1:0] != 2'h0), "sync enable");
            chk_cfg(24'(cfg.sync_word_32), 24'(i[1:0] == 2'h3), "sync width");
            chk_cfg(24'(cfg.sync_max_errors), 24'((i[1:0] == 2'h1) ? 2'h1
                : (i[1:0] == 2'h3) ? 2'h2 : 2'h0), "sync errors");
            chk_cfg(24'(cfg.carrier_sense_req), 24'(i[2]), "carrier sense");
        end
        // unmapped address: write ignored, read returns zero, neighbours untouched
        reg_wr(6'h20, 8'h5a);
        reg_rd(6'h20, 8'h00);
        reg_rd(mcr_pkg::ADDR_CARRIER_WORD_A_MID, 8'h55);
        // miso was driven inside frames and is released between them
        chk_cfg(24'({oe_seen, miso_oe}), 24'h2, "miso enable");
        end_sim();
    end
endmodule : test_modem_config_registers
`default_nettype wire
